// [gain_loop_consts.svh]
`ifndef GAIN_LOOP_CONSTS_SVH
`define GAIN_LOOP_CONSTS_SVH

// Register byte offsets
`define OFF_TIMING 5'h00
`define OFF_AVERAGE 5'h04
`define OFF_LIMIT 5'h08
`define OFF_THRESH 5'h0C
`define OFF_CTRL 5'h10
`define OFF_STATUS 5'h14
`define OFF_LEVEL 5'h18

// Reset values
`define RST_TIMING 5'h00
`define RST_AVERAGE 3'h0
`define RST_LIMIT 8'h00
`define RST_THRESH 8'h00
`define RST_CTRL 4'h0

// Field positions
`define CTRL_RX_ON 0
`define CTRL_SENSE_SET 1
`define CTRL_BLANKING 2
`define CTRL_FILTER_SKIP 3
`define AVG_HYST 2
`define STAT_HOLD 0
`define STAT_CARRIER 3
`define STAT_GAIN_LSB 8

// Timing and level figures
`define FREEZE_BASE 8'h10
`define SENSE_OFFSET 8'h08
`define DROP_OFFSET 8'h08
`define HYST_WIDEN 8'h02
`define LEVEL_MAX 7'h6A

`endif

// [gain_loop_pkg.sv]
package gain_loop_pkg;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_STARTUP,
    ST_STEP_WAIT,
    ST_MEASURE
  } loop_state_e;

  typedef struct packed {
    loop_state_e st;
    logic [7:0] cnt;
    logic [4:0] gain;
    logic cs;
    logic [6:0] level;
    logic [1:0] vote;
    logic rx_d;
    logic avg_go;
    logic ack;
    logic [31:0] rdata;
    logic [4:0] timing;
    logic [2:0] avg_cfg;
    logic [7:0] limit;
    logic [7:0] thresh;
    logic [3:0] ctrl;
  } loop_regs_s;

  typedef struct packed {
    logic busy;
    logic [1:0] sel;
    logic [4:0] cnt;
    logic [10:0] sum;
    logic done;
    logic [6:0] avg;
  } avg_regs_s;

endpackage : gain_loop_pkg

// [level_averager.sv]
`timescale 1ns/100ps
`include "gain_loop_consts.svh"
module level_averager
  import gain_loop_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic filt_ce_i,
  input wire logic start_i,
  input wire logic [1:0] avg_sel_i,
  input wire logic [6:0] sample_i,
  output logic done_o,
  output logic [6:0] avg_o
);

  avg_regs_s r;
  avg_regs_s next_r;
  logic [10:0] sum_now;
  logic [4:0] len;

  // Samples per reading are 2, 4, 8 or 16; the count is latched at start
  // so a config write mid-reading cannot strand the counter
  assign len = 5'h01 << ({1'b0, r.sel} + 3'h1);
  assign sum_now = r.sum + {4'h0, sample_i};

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    if (start_i) begin
      next_r.busy = 1'b1;
      next_r.sel = avg_sel_i;
      next_r.cnt = 5'h00;
      next_r.sum = 11'h000;
    end else if (r.busy && filt_ce_i) begin
      next_r.sum = sum_now;
      next_r.cnt = r.cnt + 5'h01;
      if (r.cnt + 5'h01 == len) begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
        next_r.avg = 7'(sum_now >> ({1'b0, r.sel} + 3'h1));
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign done_o = r.done;
  assign avg_o = r.avg;

  avg_len_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    r.busy |-> r.cnt < len) else $error("averager overran its length");

endmodule : level_averager

// [gain_loop_ctrl.sv]
// Added by the designer: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
`include "gain_loop_consts.svh"
module gain_loop_ctrl
  import gain_loop_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic [4:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic ADC_CE_I,
  input wire logic FILT_CE_I,
  input wire logic [6:0] SAMPLE_I,
  input wire logic LOCK_LOST_I,
  input wire logic FREQ_SWITCH_I,
  output logic [4:0] GAIN_O,
  output logic HOLD_O,
  output logic CARRIER_SENSE_O,
  output logic BLANK_O,
  output logic FILTER_SKIP_O
);

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  loop_regs_s r;
  loop_regs_s next_r;
  logic avg_done;
  logic [6:0] avg_val;
  logic [6:0] lvl_new;
  logic [7:0] low_lim;
  logic [7:0] high_lim;
  logic [7:0] lvl8;
  logic go_down;
  logic go_up;
  logic restart;
  logic req;

  function automatic logic [7:0] freeze_cycles(input logic [1:0] f);
    freeze_cycles = `FREEZE_BASE << f;
  endfunction : freeze_cycles

  function automatic logic [7:0] wait_cycles(input logic [2:0] w,
                                             input logic blank);
    logic [7:0] n;
    case (w)
      3'h0: n = 8'h10;
      3'h1: n = 8'h14;
      3'h2: n = 8'h18;
      3'h3: n = 8'h1C;
      3'h4: n = 8'h20;
      3'h5: n = 8'h24;
      3'h6: n = 8'h28;
      default: n = 8'h30;
    endcase
    // Blanking trades a shorter settle for more offset spikes
    wait_cycles = blank ? (n >> 1) : n;
  endfunction : wait_cycles

  level_averager u_avg (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .filt_ce_i(FILT_CE_I),
    .start_i(r.avg_go),
    .avg_sel_i(r.avg_cfg[1:0]),
    .sample_i(SAMPLE_I),
    .done_o(avg_done),
    .avg_o(avg_val)
  );

  // Filtered sample halves the jump of a single noisy reading
  assign lvl_new = r.avg_cfg[`AVG_HYST]
                 ? 7'((8'(r.level) + 8'(avg_val)) >> 1) : avg_val;
  assign lvl8 = {1'b0, lvl_new};
  assign low_lim = 8'(r.thresh[4:0]) + 8'(r.thresh[7:5]);
  assign high_lim = low_lim + 8'(r.limit[7:5]) + `DROP_OFFSET;
  always_comb begin
    if (r.avg_cfg[`AVG_HYST]) begin
      go_down = lvl8 > high_lim + `HYST_WIDEN;
      go_up = lvl8 + `HYST_WIDEN < low_lim;
    end else begin
      go_down = lvl8 > high_lim;
      go_up = lvl8 < low_lim;
    end
  end

  assign restart = r.ctrl[`CTRL_RX_ON]
                 && (!r.rx_d || LOCK_LOST_I || FREQ_SWITCH_I);
  assign req = AVS_READ_I || AVS_WRITE_I;

  always_comb begin
    next_r = r;
    next_r.avg_go = 1'b0;
    next_r.rx_d = r.ctrl[`CTRL_RX_ON];
    // Register bus: one wait state, answer on the ack cycle
    next_r.ack = req && !r.ack;
    if (req && !r.ack) begin
      next_r.rdata = 32'h0000_0000;
      if (AVS_ADDRESS_I == `OFF_TIMING) begin
        next_r.rdata[4:0] = r.timing;
      end else if (AVS_ADDRESS_I == `OFF_AVERAGE) begin
        next_r.rdata[2:0] = r.avg_cfg;
      end else if (AVS_ADDRESS_I == `OFF_LIMIT) begin
        next_r.rdata[7:0] = r.limit;
      end else if (AVS_ADDRESS_I == `OFF_THRESH) begin
        next_r.rdata[7:0] = r.thresh;
      end else if (AVS_ADDRESS_I == `OFF_CTRL) begin
        next_r.rdata[3:0] = r.ctrl;
      end else if (AVS_ADDRESS_I == `OFF_STATUS) begin
        next_r.rdata[`STAT_CARRIER] = r.cs;
        next_r.rdata[`STAT_HOLD] = HOLD_O;
        next_r.rdata[`STAT_GAIN_LSB +: 5] = r.gain;
      end else if (AVS_ADDRESS_I == `OFF_LEVEL) begin
        next_r.rdata[6:0] = r.level;
      end
    end
    if (AVS_WRITE_I && r.ack && AVS_BYTEENABLE_I[0]) begin
      if (AVS_ADDRESS_I == `OFF_TIMING) begin
        next_r.timing = AVS_WRITEDATA_I[4:0];
      end else if (AVS_ADDRESS_I == `OFF_AVERAGE) begin
        next_r.avg_cfg = AVS_WRITEDATA_I[2:0];
      end else if (AVS_ADDRESS_I == `OFF_LIMIT) begin
        next_r.limit = AVS_WRITEDATA_I[7:0];
      end else if (AVS_ADDRESS_I == `OFF_THRESH) begin
        next_r.thresh = AVS_WRITEDATA_I[7:0];
      end else if (AVS_ADDRESS_I == `OFF_CTRL) begin
        next_r.ctrl = AVS_WRITEDATA_I[3:0];
      end
    end
    // Gain loop
    if (!r.ctrl[`CTRL_RX_ON]) begin
      next_r.st = ST_OFF;
      next_r.cs = 1'b0;
      next_r.cnt = 8'h00;
    end else if (restart) begin
      next_r.st = ST_STARTUP;
      next_r.cnt = 8'h00;
      next_r.cs = 1'b0;
      next_r.vote = 2'b00;
      if (!r.rx_d) begin
        next_r.gain = r.limit[4:0];
      end
    end else begin
      case (r.st)
        ST_STARTUP: begin
          next_r.cs = 1'b0;
          if (ADC_CE_I) begin
            if (r.cnt == freeze_cycles(r.timing[4:3]) - 8'h01) begin
              next_r.st = ST_STEP_WAIT;
              next_r.cnt = 8'h00;
            end else begin
              next_r.cnt = r.cnt + 8'h01;
            end
          end
        end
        ST_STEP_WAIT: begin
          next_r.cs = 1'b0;
          if (FILT_CE_I) begin
            if (r.cnt == wait_cycles(r.timing[2:0],
                                     r.ctrl[`CTRL_BLANKING]) - 8'h01) begin
              next_r.st = ST_MEASURE;
              next_r.cnt = 8'h00;
              next_r.avg_go = 1'b1;
            end else begin
              next_r.cnt = r.cnt + 8'h01;
            end
          end
        end
        ST_MEASURE: begin
          if (avg_done) begin
            next_r.level = lvl_new;
            if (!r.ctrl[`CTRL_SENSE_SET]) begin
              next_r.cs = lvl8 > 8'(r.thresh[4:0]) + `SENSE_OFFSET;
            end else if (lvl8 > 8'(r.thresh[4:0]) + `SENSE_OFFSET) begin
              next_r.cs = 1'b1;
            end
            next_r.vote = {go_up, go_down};
            next_r.avg_go = 1'b1;
            if (go_down && r.gain != 5'h00
                && (!r.avg_cfg[`AVG_HYST] || r.vote == 2'b01)) begin
              next_r.gain = r.gain - 5'h01;
              next_r.st = ST_STEP_WAIT;
              next_r.avg_go = 1'b0;
              next_r.vote = 2'b00;
              next_r.cs = 1'b0;
            end else if (go_up && r.gain < r.limit[4:0]
                && (!r.avg_cfg[`AVG_HYST] || r.vote == 2'b10)) begin
              next_r.gain = r.gain + 5'h01;
              next_r.st = ST_STEP_WAIT;
              next_r.avg_go = 1'b0;
              next_r.vote = 2'b00;
              next_r.cs = 1'b0;
            end
          end
        end
        default: begin
          next_r.st = ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      r <= '0;
      r.st <= ST_OFF;
      r.timing <= `RST_TIMING;
      r.avg_cfg <= `RST_AVERAGE;
      r.limit <= `RST_LIMIT;
      r.thresh <= `RST_THRESH;
      r.ctrl <= `RST_CTRL;
    end else begin
      r <= next_r;
    end
  end

  assign AVS_READDATA_O = r.rdata;
  assign AVS_WAITREQUEST_O = req && !r.ack;
  assign GAIN_O = r.gain;
  assign HOLD_O = (r.st == ST_STARTUP) || (r.st == ST_STEP_WAIT);
  assign CARRIER_SENSE_O = r.cs;
  assign BLANK_O = (r.st == ST_STEP_WAIT) && r.ctrl[`CTRL_BLANKING];
  // Image rejection degrades while the host keeps this set
  assign FILTER_SKIP_O = r.ctrl[`CTRL_FILTER_SKIP];

  sense_in_hold_a: assert property (HOLD_O |-> !r.cs)
    else $error("carrier sense during hold");
  power_up_a: assert property ($rose(r.ctrl[`CTRL_RX_ON])
    |=> r.st == ST_STARTUP) else $error("no startup hold after power-up");
  startup_len_a: assert property ((r.st == ST_STARTUP)
    |-> r.cnt < freeze_cycles(r.timing[4:3]))
    else $error("startup hold too long");
  gain_down_a: assert property ((r.st == ST_MEASURE && avg_done
    && !restart && r.ctrl[`CTRL_RX_ON] && !r.avg_cfg[`AVG_HYST]
    && go_down && r.gain != 5'h00)
    |=> r.gain == $past(r.gain) - 5'h01 && r.st == ST_STEP_WAIT)
    else $error("gain not lowered");
  gain_up_a: assert property ((r.st == ST_MEASURE && avg_done
    && !restart && r.ctrl[`CTRL_RX_ON] && !r.avg_cfg[`AVG_HYST]
    && !go_down && go_up && r.gain < r.limit[4:0])
    |=> r.gain == $past(r.gain) + 5'h01 && r.st == ST_STEP_WAIT)
    else $error("gain not raised");
  sense_set_a: assert property ((r.st == ST_MEASURE && avg_done
    && !restart && r.ctrl[`CTRL_RX_ON] && !r.ctrl[`CTRL_SENSE_SET]
    && !go_down && !go_up && lvl8 > 8'(r.thresh[4:0]) + `SENSE_OFFSET)
    |=> r.cs) else $error("carrier sense not set");
  status_bit_a: assert property ((AVS_READ_I && !r.ack
    && AVS_ADDRESS_I == `OFF_STATUS)
    |=> AVS_READDATA_O[`STAT_CARRIER] == $past(r.cs) && !AVS_WAITREQUEST_O)
    else $error("status bit 3 not carrier sense");
  level_range_a: assert property (r.level <= `LEVEL_MAX)
    else $error("level reading out of range");

endmodule : gain_loop_ctrl

// [front_end_model.sv]
`timescale 1ns/100ps
module front_end_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [4:0] gain_i,
  input wire logic [6:0] base_i,
  output logic adc_ce_o,
  output logic filt_ce_o,
  output logic [6:0] sample_o
);
  logic [1:0] div;
  logic [7:0] sum;
  // Converter enable every 2nd cycle, filter enable every 4th
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)
      div <= 2'h0;
    else
      div <= div + 2'h1;
  end
  assign adc_ce_o = div[0];
  assign filt_ce_o = (div == 2'h3);
  // Seen level climbs one count per gain code, clipped at full scale
  assign sum = {1'b0, base_i} + {3'h0, gain_i};
  assign sample_o = (sum > 8'h6A) ? 7'h6A : sum[6:0];
endmodule : front_end_model

// [tb_top.sv]
`timescale 1ns/100ps
`include "gain_loop_consts.svh"
module tb_top;
  import gain_loop_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0;
  logic lock = 1'b0, fsw = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] be = 4'hF;
  logic [6:0] base = 7'h00;
  logic [31:0] rdata, q;
  logic wq, adc_ce, filt_ce, hold, cs, blank, skip;
  logic [6:0] sample;
  logic [4:0] gain;
  int n_fail = 0, comparisons = 0, cyc = 0;
  int g, lvl, n, w, xp, xg, dx, op, og;

  always #50 clk = ~clk;

  gain_loop_ctrl i_dut (.CLK_I(clk), .RSTN_I(rstn), .AVS_ADDRESS_I(addr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
    .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(wq), .ADC_CE_I(adc_ce), .FILT_CE_I(filt_ce),
    .SAMPLE_I(sample), .LOCK_LOST_I(lock), .FREQ_SWITCH_I(fsw),
    .GAIN_O(gain), .HOLD_O(hold), .CARRIER_SENSE_O(cs),
    .BLANK_O(blank), .FILTER_SKIP_O(skip));

  front_end_model i_fe (.clk_i(clk), .rstn_i(rstn), .gain_i(gain),
    .base_i(base), .adc_ce_o(adc_ce), .filt_ce_o(filt_ce),
    .sample_o(sample));

  task finish_test();
    $display("mismatches %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // Ceiling well above the roughly 12k cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      finish_test();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One idle edge before each request keeps strobes single-driven
  task bus(input logic w_i, input logic [4:0] a, input logic [7:0] d,
           input logic [3:0] b);
    int k;
    k = 0;
    @(posedge clk);
    rd <= !w_i;
    wr <= w_i;
    addr <= a;
    wdata <= {24'h00_0000, d};
    be <= b;
    do begin
      @(negedge clk);
      k++;
    end while (wq !== 1'b0 && k < 50);
    if (k >= 50)
      n_fail++;
    @(posedge clk);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task rchk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00, 4'hF);
    chk(q, exp);
  endtask : rchk

  function automatic int wait_len(input int f, input int wt);
    return 2 * (16 << f) + 4 * ((wt == 7) ? 48 : 16 + 4 * wt);
  endfunction : wait_len

  // Host view of the image level: eight readings averaged per trim value
  function automatic int img(input int x, input int opt);
    int s;
    s = 0;
    for (int k = 0; k < 8; k++)
      s += (x - opt) * (x - opt);
    return s / 8;
  endfunction : img

  // One host pass over five trim values, returns the new estimate
  function automatic int cal_step(input int x, input int d, input int opt);
    int y[5];
    int a, s, num, den;
    for (int k = 0; k < 5; k++)
      y[k] = img((x + (k - 2) * d > 127) ? 127 : x + (k - 2) * d, opt);
    a = 2 * (y[0] - y[2] + y[4]) - (y[1] + y[3]);
    num = 7 * d * (2 * (y[0] - y[4]) + y[1] - y[3]);
    den = 10 * a;
    if (a <= 0)
      s = -d;
    else if (num >= 0)
      s = (num + den / 2) / den;
    else
      s = -((den / 2 - num) / den);
    if (s > d)
      s = d;
    else if (s < -d)
      s = -d;
    return x + s;
  endfunction : cal_step

  // Counts hold cycles; carrier sense must stay low meanwhile
  task hold_len(output int c);
    c = 0;
    while (hold !== 1'b0 && c < 3000) begin
      @(posedge clk);
      #1;
      c++;
      chk({31'h0, cs}, 32'h0);
    end
  endtask : hold_len

  initial begin
    n = $urandom(66843);
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (int a = 0; a <= 28; a += 4)
      rchk(a[4:0], 32'h0000_0000);
    bus(1'b1, `OFF_TIMING, 8'h1F, 4'hE);
    rchk(`OFF_TIMING, 32'h0000_0000);
    bus(1'b1, 5'h1C, 8'hFF, 4'hF);
    rchk(5'h1C, 32'h0000_0000);
    base <= 7'h64;
    for (int f = 0; f < 4; f++) begin
      w = $urandom_range(7);
      bus(1'b1, `OFF_TIMING, 8'(f * 8 + w), 4'hF);
      bus(1'b1, `OFF_LIMIT, 8'h66, 4'hF);
      bus(1'b1, `OFF_CTRL, 8'h01, 4'hF);
      @(posedge clk);
      #1;
      chk({27'h0, gain}, 32'h0000_0006);
      hold_len(n);
      chk(32'(n > wait_len(f, w) - 12 && n < wait_len(f, w) + 12), 1);
      bus(1'b1, `OFF_CTRL, 8'h00, 4'hF);
    end
    // Levels inside the band: low limit 21, high limit 32, sense above 28
    bus(1'b1, `OFF_THRESH, 8'h34, 4'hF);
    bus(1'b1, `OFF_TIMING, 8'h00, 4'hF);
    repeat (3) begin
      g = $urandom_range(12, 4);
      lvl = $urandom_range(32, 21);
      base <= 7'(lvl - g);
      bus(1'b1, `OFF_LIMIT, 8'(8'h60 + g), 4'hF);
      bus(1'b1, `OFF_AVERAGE, 8'($urandom_range(3)), 4'hF);
      bus(1'b1, `OFF_CTRL, 8'h01, 4'hF);
      repeat (1500) @(posedge clk);
      chk({27'h0, gain}, 32'(g));
      chk({31'h0, cs}, 32'(lvl > 28));
      rchk(`OFF_LEVEL, 32'(lvl));
      rchk(`OFF_STATUS, 32'(g * 256 + (lvl > 28) * 8));
      bus(1'b1, `OFF_CTRL, 8'h00, 4'hF);
    end
    // Strong signal steps gain down; blanking and skip bits are on
    base <= 7'h64;
    bus(1'b1, `OFF_LIMIT, 8'h68, 4'hF);
    bus(1'b1, `OFF_AVERAGE, 8'h04, 4'hF);
    bus(1'b1, `OFF_CTRL, 8'h0D, 4'hF);
    @(posedge clk);
    #1;
    n = 0;
    while (gain === 5'h08 && n < 600) begin
      @(posedge clk);
      n++;
    end
    #1;
    chk({27'h0, gain}, 32'h0000_0007);
    chk({29'h0, hold, blank, skip}, 32'h0000_0007);
    base <= 7'h00;
    repeat (2500) @(posedge clk);
    chk({27'h0, gain}, 32'h0000_0008);
    base <= 7'h64;
    repeat (4000) @(posedge clk);
    chk({27'h0, gain}, 32'h0000_0000);
    for (int i = 0; i < 2; i++) begin
      n = 0;
      while (hold !== 1'b0 && n < 600) begin
        @(posedge clk);
        n++;
      end
      @(posedge clk);
      lock <= (i == 0);
      fsw <= (i == 1);
      @(posedge clk);
      lock <= 1'b0;
      fsw <= 1'b0;
      #1;
      chk({31'h0, hold}, 32'h0000_0001);
      chk({31'h0, cs}, 32'h0000_0000);
    end
    // Host image search over a model whose minimum is drawn at random
    op = $urandom_range(100, 10);
    og = $urandom_range(100, 10);
    xp = 0;
    xg = 0;
    dx = 64;
    xp = cal_step(xp, dx, op);
    xg = cal_step(xg, dx, og);
    while (dx > 1) begin
      dx = dx / 2;
      xp = cal_step(xp, dx, op);
      xg = cal_step(xg, dx, og);
    end
    chk(32'(xp > op - 4 && xp < op + 4), 1);
    chk(32'(xg > og - 4 && xg < og + 4), 1);
    finish_test();
  end
endmodule : tb_top
